// File: logic/mic_consts.svh
`ifndef MIC_CONSTS_SVH
`define MIC_CONSTS_SVH
// Register byte offsets on the bus
`define MIC_OFF_CTRL 8'h00
`define MIC_OFF_POL 8'h04
`define MIC_OFF_PIE 8'h08
`define MIC_OFF_PEN 8'h0C
`define MIC_OFF_STAT 8'h10
// Reset values
`define MIC_MASK_RESET 1'h1
`define MIC_POL_RESET 4'h0
`define MIC_PIE_RESET 15'h0000
`define MIC_PEN_RESET 16'h0000
`define MIC_SP_RESET 8'hFF
`define MIC_SP_PAGE 8'h01
// Field positions
`define MIC_CC_I_BIT 3
`define MIC_POL01_LO 0
`define MIC_POL23_LO 2
// Sensitivity codes, {hi,lo}
`define MIC_POL_FALL_LOW 2'h0
`define MIC_POL_RISE 2'h1
// Timing: oscillator stabilization, in CPU cycles
`define MIC_STAB_CYCLES 13'h1000
`define MIC_PUSH_LAST 3'h4
// Vector base addresses (even byte of each pair)
`define MIC_VEC_RESET 16'hFFFE
`define MIC_VEC_TRAP 16'hFFFC
`define MIC_VEC_EXT0 16'hFFF6
`define MIC_VEC_EXT1 16'hFFF4
`define MIC_VEC_EXT2 16'hFFF2
`define MIC_VEC_EXT3 16'hFFF0
`define MIC_VEC_SYNC 16'hFFEC
`define MIC_VEC_TIMA 16'hFFEA
`define MIC_VEC_TIMB 16'hFFE8
`define MIC_VEC_ASYNC 16'hFFE6
`endif

// File: logic/mic_core.sv
// Summary of operation
// - Maskable requests serviced only with mask clear
// - Entry starts at instruction end, or on wake from Wait or Halt
// - Entry pushes PC, X, A, CC
// - Entry sets the global mask
// - Load PC from selected source vector
// - Return restores context, clears mask
// - Fixed priority resolves simultaneous requests
// - Trap enters regardless of mask
// - Any source wakes Wait; external wakes Halt
// - External vector needs event and clear mask
// - Edge latch cleared on service entry
// - Enabled pins of group are combined
// - Low enabled pin blocks group request
// - Peripheral flag needs enable and clear mask
// - Clear sequence drops the request latch
// - Reset and trap use top vectors
// - Line zero: port A 0-3, wakes Halt
// - Line one: port F 0-2, wakes Halt
// - Line two: port B 0-3, wakes Halt
// - Line three: port B 4-7, wakes Halt
// - Each peripheral shares one vector
// - Four sensitivities per two-bit polarity field
// - Halt wake waits stabilization count first
// - Entering Wait clears the global mask
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mic_consts.svh"
module mic_core (
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  input  wire logic [3:0]  port_a_pin_in,
  input  wire logic [2:0]  port_f_pin_in,
  input  wire logic [7:0]  port_b_pin_in,
  input  wire logic [15:0] periph_flag_in,
  input  wire logic [3:0]  periph_clr_in,
  input  wire logic        instr_end_in,
  input  wire logic        trap_in,
  input  wire logic        return_from_service_instruction_in,
  input  wire logic        wait_in,
  input  wire logic        halt_in,
  input  wire logic [15:0] pc_in,
  input  wire logic [7:0]  x_in,
  input  wire logic [7:0]  a_in,
  input  wire logic [7:0]  cc_in,
  input  wire logic [7:0]  stack_rdata_in,
  output logic             stack_we_out,
  output logic             stack_re_out,
  output logic [15:0]      stack_addr_out,
  output logic [7:0]       stack_wdata_out,
  output logic             restore_we_out,
  output logic [2:0]       restore_sel_out,
  output logic [7:0]       restore_data_out,
  output logic             vec_load_out,
  output logic [15:0]      vec_addr_out,
  output logic             core_hold_out,
  output logic             osc_en_out,
  output logic             mask_out
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  mic_pkg::mic_state_t state_q;     // Sequencer state
  mic_pkg::mic_src_t   sel_q;       // Source being serviced
  mic_pkg::mic_src_t   win_src;     // Priority winner
  logic        mask_q;              // Global interrupt mask
  logic        mask_sv_q;           // Mask value before entry
  logic [3:0]  pol_q;               // Two polarity fields
  logic [14:0] pie_q;               // Pin interrupt enables
  logic [15:0] pen_q;               // Peripheral flag enables
  logic [7:0]  sp_q;                // Stack pointer low byte
  logic [2:0]  cnt_q;               // Push and pop byte count
  logic [12:0] stab_q;              // Stabilization count
  logic        rst_wake_q;          // Reset vector still owed
  logic [14:0] pin_s1_q;            // Pin synchroniser stage 1
  logic [14:0] pin_s2_q;            // Pin synchroniser stage 2
  logic [3:0]  lvl_prev_q;          // Line level last cycle
  logic [3:0]  ext_lat_q;           // External edge latches
  logic [3:0]  per_lat_q;           // Peripheral request latches
  logic [3:0]  lvl;                 // Combined line level
  logic [3:0]  act;                 // Line has an enabled pin
  logic [3:0]  ext_req;             // External requests
  logic [3:0]  ext_clr;             // Latch clear on entry
  logic [3:0]  grp_flag;            // Any flag of a peripheral
  logic [3:0]  grp_hit;             // Any enabled flag
  logic [7:0]  req_all;             // All maskable requests
  logic        take;                // Maskable entry now
  logic        wr_pend_q;           // Bus write in data phase
  logic [7:0]  waddr_q;             // Bus write address
  logic [31:0] rdata_q;             // Bus read data
  logic        rd_pend_q;           // Stack read in flight
  logic        rest_we_q;           // Restore write strobe
  logic [2:0]  rd_sel_q;            // Byte being restored
  logic        we_q;                // Stack write strobe
  logic        re_q;                // Stack read strobe
  logic [15:0] saddr_q;             // Stack address
  logic [7:0]  swdata_q;            // Stack write data
  logic [7:0]  rest_q;              // Restored byte
  logic        vld_q;               // Vector load strobe
  logic [15:0] vaddr_q;             // Vector address

  ////////////////////////////////////////////////////////////////////
  // Pin synchroniser, two stages
  always_ff @(posedge core_clk_in)
  begin
    pin_s1_q <= {port_b_pin_in, port_f_pin_in, port_a_pin_in};
    pin_s2_q <= pin_s1_q;
  end

  // Group combine: any low enabled pin pulls the line low
  assign lvl[0] = &(pin_s2_q[3:0] | ~pie_q[3:0]);
  assign lvl[1] = &(pin_s2_q[6:4] | ~pie_q[6:4]);
  assign lvl[2] = &(pin_s2_q[10:7] | ~pie_q[10:7]);
  assign lvl[3] = &(pin_s2_q[14:11] | ~pie_q[14:11]);
  assign act    = {|pie_q[14:11], |pie_q[10:7], |pie_q[6:4], |pie_q[3:0]};

  // Previous line level for edge detection
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      lvl_prev_q <= 4'hF;
    else
      lvl_prev_q <= lvl;
  end

  ////////////////////////////////////////////////////////////////////
  // Edge and level detection per line
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_line
      logic [1:0] pol;    // Field shared by line pair
      logic       fall;   // Falling edge seen
      logic       rise;   // Rising edge seen
      logic       ev;     // Selected edge seen
      assign pol  = (gi < 2) ? pol_q[`MIC_POL01_LO +: 2] : pol_q[`MIC_POL23_LO +: 2];
      assign fall = lvl_prev_q[gi] & ~lvl[gi];
      assign rise = ~lvl_prev_q[gi] & lvl[gi];
      assign ev   = act[gi] & ((fall & (pol != `MIC_POL_RISE)) | (rise & pol[0]));
      // Edge latch, new edge wins over entry clear
      always_ff @(posedge core_clk_in)
      begin
        if (reset_in)
          ext_lat_q[gi] <= 1'b0;
        else if (ev)
          ext_lat_q[gi] <= 1'b1;
        else if (ext_clr[gi])
          ext_lat_q[gi] <= 1'b0;
      end
      // Low level also requests in the default mode
      assign ext_req[gi] = ext_lat_q[gi]
                         | (act[gi] & (pol == `MIC_POL_FALL_LOW) & ~lvl[gi]);
      assign ext_clr[gi] = take && (win_src == mic_pkg::mic_src_t'(gi));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Peripheral groups: sync serial, timer A, timer B, async serial
  assign grp_flag = {|periph_flag_in[15:11], |periph_flag_in[10:7],
                     |periph_flag_in[6:2], |periph_flag_in[1:0]};
  assign grp_hit  = {|(periph_flag_in[15:11] & pen_q[15:11]),
                     |(periph_flag_in[10:7] & pen_q[10:7]),
                     |(periph_flag_in[6:2] & pen_q[6:2]),
                     |(periph_flag_in[1:0] & pen_q[1:0])};

  // Request latches; the peripheral's clear sequence empties them
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      per_lat_q <= 4'h0;
    else
      per_lat_q <= grp_flag | (per_lat_q & ~periph_clr_in);
  end

  // Pending but unenabled stays latched
  assign req_all = {per_lat_q & grp_hit, ext_req};

  ////////////////////////////////////////////////////////////////////
  // Fixed priority, lowest index wins
  always_comb
  begin
    win_src = mic_pkg::SRC_ASYNC;
    for (int i = 7; i >= 0; i--)
    begin
      if (req_all[i])
        win_src = mic_pkg::mic_src_t'(i[3:0]);
    end
  end

  // Maskable entry at instruction end with mask clear, on any request in Wait, or after Halt stabilization
  assign take = ((state_q == mic_pkg::ST_RUN) && instr_end_in && !trap_in
                 && !mask_q && (|req_all))
             || ((state_q == mic_pkg::ST_WAIT) && (|req_all))
             || ((state_q == mic_pkg::ST_STAB) && !rst_wake_q
                 && (stab_q == `MIC_STAB_CYCLES - 13'h1) && (|ext_req));

  ////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      state_q    <= mic_pkg::ST_STAB;
      sel_q      <= mic_pkg::SRC_RESET;
      cnt_q      <= 3'h0;
      stab_q     <= 13'h0000;
      rst_wake_q <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        mic_pkg::ST_RUN:
        begin
          cnt_q <= 3'h0;
          if (instr_end_in && trap_in)
          begin
            state_q <= mic_pkg::ST_PUSH;
            sel_q   <= mic_pkg::SRC_TRAP;
          end
          else if (take)
          begin
            state_q <= mic_pkg::ST_PUSH;
            sel_q   <= win_src;
          end
          else if (instr_end_in && return_from_service_instruction_in)
            state_q <= mic_pkg::ST_POP;
          else if (instr_end_in && wait_in)
            state_q <= mic_pkg::ST_WAIT;
          else if (instr_end_in && halt_in)
            state_q <= mic_pkg::ST_HALT;
        end
        mic_pkg::ST_STAB:
        begin
          // Oscillator settles before anything is serviced
          if (stab_q == `MIC_STAB_CYCLES - 13'h1)
          begin
            stab_q <= 13'h0000;
            if (rst_wake_q)
            begin
              state_q    <= mic_pkg::ST_VEC;
              rst_wake_q <= 1'b0;
            end
            else if (take)
            begin
              state_q <= mic_pkg::ST_PUSH;
              sel_q   <= win_src;
            end
            else
              state_q <= mic_pkg::ST_RUN;
          end
          else
            stab_q <= stab_q + 13'h1;
        end
        mic_pkg::ST_PUSH:
        begin
          // Five bytes then the vector
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `MIC_PUSH_LAST)
            state_q <= mic_pkg::ST_VEC;
        end
        mic_pkg::ST_VEC:
          state_q <= mic_pkg::ST_RUN;
        mic_pkg::ST_WAIT:
        begin
          // Any request ends the wait
          if (take)
          begin
            state_q <= mic_pkg::ST_PUSH;
            sel_q   <= win_src;
          end
        end
        mic_pkg::ST_HALT:
        begin
          // Only external lines restart the oscillator
          if (|ext_req)
            state_q <= mic_pkg::ST_STAB;
        end
        mic_pkg::ST_POP:
        begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `MIC_PUSH_LAST)
          begin
            state_q <= mic_pkg::ST_RUN;
            cnt_q   <= 3'h0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Global mask: entry sets it, wait, halt and return clear it
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      mask_q    <= `MIC_MASK_RESET;
      mask_sv_q <= `MIC_MASK_RESET;
    end
    else if (state_q != mic_pkg::ST_PUSH && state_q != mic_pkg::ST_VEC
             && (take || (state_q == mic_pkg::ST_RUN && instr_end_in && trap_in)))
    begin
      mask_q    <= 1'b1;
      mask_sv_q <= mask_q;
    end
    else if (state_q == mic_pkg::ST_RUN && instr_end_in && (wait_in || halt_in)
             && !return_from_service_instruction_in)
      mask_q <= 1'b0;
    else if (state_q == mic_pkg::ST_POP && cnt_q == 3'h0)
      mask_q <= 1'b0;
    else if (wr_pend_q && waddr_q == `MIC_OFF_CTRL)
      mask_q <= hwdata_in[0];
  end

  ////////////////////////////////////////////////////////////////////
  // Stack port: push PCL, PCH, X, A, CC; pop in reverse
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      sp_q      <= `MIC_SP_RESET;
      we_q      <= 1'b0;
      re_q      <= 1'b0;
      saddr_q   <= 16'h0000;
      swdata_q  <= 8'h00;
      rd_pend_q <= 1'b0;
      rest_we_q <= 1'b0;
      rd_sel_q  <= 3'h0;
      rest_q    <= 8'h00;
    end
    else
    begin
      we_q      <= state_q == mic_pkg::ST_PUSH;
      re_q      <= state_q == mic_pkg::ST_POP;
      rd_pend_q <= re_q;
      rest_we_q <= rd_pend_q;
      // RAM answers one cycle after the read strobe
      if (rd_pend_q)
        rest_q <= stack_rdata_in;
      // First restored byte is CC, then down to PCL
      if (state_q == mic_pkg::ST_POP && cnt_q == 3'h0)
        rd_sel_q <= `MIC_PUSH_LAST;
      else if (rest_we_q && rd_sel_q != 3'h0)
        rd_sel_q <= rd_sel_q - 3'h1;
      if (state_q == mic_pkg::ST_PUSH)
      begin
        saddr_q <= {`MIC_SP_PAGE, sp_q};
        sp_q    <= sp_q - 8'h01;
        unique case (cnt_q)
          3'h0: swdata_q <= pc_in[7:0];
          3'h1: swdata_q <= pc_in[15:8];
          3'h2: swdata_q <= x_in;
          3'h3: swdata_q <= a_in;
          default:
          begin
            swdata_q <= cc_in;
            swdata_q[`MIC_CC_I_BIT] <= mask_sv_q;
          end
        endcase
      end
      else if (state_q == mic_pkg::ST_POP)
      begin
        saddr_q <= {`MIC_SP_PAGE, sp_q + 8'h01};
        sp_q    <= sp_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Vector load strobe and address
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      vld_q   <= 1'b0;
      vaddr_q <= `MIC_VEC_RESET;
    end
    else
    begin
      vld_q <= state_q == mic_pkg::ST_VEC;
      unique case (sel_q)
        mic_pkg::SRC_RESET: vaddr_q <= `MIC_VEC_RESET;
        mic_pkg::SRC_TRAP:  vaddr_q <= `MIC_VEC_TRAP;
        mic_pkg::SRC_EXT0:  vaddr_q <= `MIC_VEC_EXT0;
        mic_pkg::SRC_EXT1:  vaddr_q <= `MIC_VEC_EXT1;
        mic_pkg::SRC_EXT2:  vaddr_q <= `MIC_VEC_EXT2;
        mic_pkg::SRC_EXT3:  vaddr_q <= `MIC_VEC_EXT3;
        mic_pkg::SRC_SYNC:  vaddr_q <= `MIC_VEC_SYNC;
        mic_pkg::SRC_TIMA:  vaddr_q <= `MIC_VEC_TIMA;
        mic_pkg::SRC_TIMB:  vaddr_q <= `MIC_VEC_TIMB;
        default:            vaddr_q <= `MIC_VEC_ASYNC;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      wr_pend_q <= 1'b0;
      waddr_q   <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end
    else if (hready_in)
    begin
      wr_pend_q <= hsel_in && htrans_in[1] && hwrite_in && haddr_in[31:8] == 24'h0;
      waddr_q   <= haddr_in[7:0];
      rdata_q   <= 32'h0000_0000;
      if (hsel_in && htrans_in[1] && !hwrite_in && haddr_in[31:8] == 24'h0)
      begin
        unique case (haddr_in[7:0])
          `MIC_OFF_CTRL: rdata_q <= {31'h0, mask_q};
          `MIC_OFF_POL:  rdata_q <= {28'h0, pol_q};
          `MIC_OFF_PIE:  rdata_q <= {17'h0, pie_q};
          `MIC_OFF_PEN:  rdata_q <= {16'h0, pen_q};
          `MIC_OFF_STAT: rdata_q <= {17'h0, state_q, sel_q, req_all};
          default:       rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      pol_q <= `MIC_POL_RESET;
      pie_q <= `MIC_PIE_RESET;
      pen_q <= `MIC_PEN_RESET;
    end
    else if (wr_pend_q)
    begin
      if (waddr_q == `MIC_OFF_POL)
        pol_q <= hwdata_in[3:0];
      if (waddr_q == `MIC_OFF_PIE)
        pie_q <= hwdata_in[14:0];
      if (waddr_q == `MIC_OFF_PEN)
        pen_q <= hwdata_in[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign hreadyout_out    = 1'b1;
  assign hresp_out        = 1'b0;
  assign hrdata_out       = rdata_q;
  assign stack_we_out     = we_q;
  assign stack_re_out     = re_q;
  assign stack_addr_out   = saddr_q;
  assign stack_wdata_out  = swdata_q;
  assign restore_we_out   = rest_we_q;
  assign restore_sel_out  = rd_sel_q;
  assign restore_data_out = rest_q;
  assign vec_load_out     = vld_q;
  assign vec_addr_out     = vaddr_q;
  assign core_hold_out    = (state_q != mic_pkg::ST_RUN) || re_q || rd_pend_q || rest_we_q;
  assign osc_en_out       = state_q != mic_pkg::ST_HALT;
  assign mask_out         = mask_q;

  ////////////////////////////////////////////////////////////////////
  // Assertions
  a_mask_blocks_entry: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_q == mic_pkg::ST_RUN && instr_end_in && !trap_in && mask_q)
    |=> state_q != mic_pkg::ST_PUSH)
    else $error("entry taken while masked");

  a_entry_sets_mask: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_q == mic_pkg::ST_PUSH) |-> mask_q)
    else $error("mask clear during entry");

  a_push_five_bytes: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $rose(state_q == mic_pkg::ST_PUSH) |-> (state_q == mic_pkg::ST_PUSH)[*5]
    ##1 state_q == mic_pkg::ST_VEC)
    else $error("push not five bytes");

  a_vec_strobe: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_q == mic_pkg::ST_VEC) |=> vld_q ##1 (!vld_q && state_q == mic_pkg::ST_RUN))
    else $error("vector strobe wrong");

  a_trap_unmasked: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_q == mic_pkg::ST_RUN && instr_end_in && trap_in)
    |=> (state_q == mic_pkg::ST_PUSH && sel_q == mic_pkg::SRC_TRAP))
    else $error("trap not entered");

  a_ext0_first: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_q == mic_pkg::ST_RUN && instr_end_in && !trap_in && !mask_q && req_all[0])
    |=> sel_q == mic_pkg::SRC_EXT0)
    else $error("priority order broken");

  a_halt_stays: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_q == mic_pkg::ST_HALT && !(|ext_req)) |=> state_q == mic_pkg::ST_HALT)
    else $error("halt left without external");

  a_halt_stab: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_q == mic_pkg::ST_HALT && (|ext_req)) |=> (state_q == mic_pkg::ST_STAB)[*8])
    else $error("halt wake skipped stabilization");

  a_return_unmask: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_q == mic_pkg::ST_POP && cnt_q == 3'h0) |=> !mask_q)
    else $error("return kept mask");

  a_wait_unmasked: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_q == mic_pkg::ST_WAIT) |-> !mask_q)
    else $error("mask set during wait");

endmodule
`default_nettype wire

// File: logic/mic_pkg.sv
`default_nettype none
package mic_pkg;
  // Sequencer states
  typedef enum logic [2:0] {ST_RUN, ST_STAB, ST_PUSH, ST_VEC, ST_WAIT, ST_HALT,
                            ST_POP} mic_state_t;
  // Sources in priority order, highest maskable first
  typedef enum logic [3:0] {SRC_EXT0, SRC_EXT1, SRC_EXT2, SRC_EXT3, SRC_SYNC,
                            SRC_TIMA, SRC_TIMB, SRC_ASYNC, SRC_TRAP,
                            SRC_RESET} mic_src_t;
endpackage
`default_nettype wire

// File: verif/mcu_interrupt_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_interrupt_controller_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwr = 1'b0;
  logic [1:0]  htr = 2'h0;
  logic [31:0] hadr = 32'h0;
  logic [31:0] hwd = 32'h0;
  logic [3:0]  pa = 4'hF;
  logic [3:0]  clr = 4'h0;
  logic [15:0] flg = 16'h0;
  logic        iend = 1'b0;
  logic        trp = 1'b0;
  logic        irt = 1'b0;
  logic        wt = 1'b0;
  logic        ht = 1'b0;
  logic [2:0]  pf = 3'h7;
  logic [7:0]  pb = 8'hFF;
  wire         hrdy, swe, sre, vld, hold, msk, rwe, osc;
  wire  [31:0] hrd;
  wire  [15:0] sadr, vadr;
  wire  [7:0]  swd, srd, npush, rdat;
  wire  [2:0]  rsel;
  logic [7:0]  rsv [0:7];
  int          n_mismatch = 0;
  int          comparisons = 0;
  logic [15:0] va;
  logic [31:0] rd;
  //////////////////////////////////////////////////////////////////////
  mic_core dut (.core_clk_in(clk), .reset_in(rst), .hsel_in(hsel), .haddr_in(hadr),
    .htrans_in(htr), .hwrite_in(hwr), .hsize_in(3'h2), .hwdata_in(hwd), .hready_in(hrdy),
    .hreadyout_out(hrdy), .hresp_out(), .hrdata_out(hrd), .port_a_pin_in(pa),
    .port_f_pin_in(pf), .port_b_pin_in(pb), .periph_flag_in(flg), .periph_clr_in(clr),
    .instr_end_in(iend), .trap_in(trp), .return_from_service_instruction_in(irt), .wait_in(wt), .halt_in(ht),
    .pc_in(16'h1234), .x_in(8'h56), .a_in(8'h78), .cc_in(8'h00), .stack_rdata_in(srd),
    .stack_we_out(swe), .stack_re_out(sre), .stack_addr_out(sadr), .stack_wdata_out(swd),
    .restore_we_out(rwe), .restore_sel_out(rsel), .restore_data_out(rdat), .vec_load_out(vld),
    .vec_addr_out(vadr), .core_hold_out(hold), .osc_en_out(osc), .mask_out(msk));
  mic_stack_model u_stk (.clk_in(clk), .reset_in(rst), .we_in(swe), .re_in(sre),
    .addr_in(sadr), .wdata_in(swd), .rdata_out(srd), .n_push_out(npush));
  // Record each restored byte by its select
  always @(posedge clk)
    if (rwe === 1'b1) rsv[rsel] <= rdat;
  //////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial forever #2 clk = ~clk;
  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end
  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One single AHB-Lite transfer, waits on hready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {hsel, htr, hwr, hadr} <= {1'b1, 2'h2, wr, 24'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    {hsel, htr, hwd} <= {1'b0, 2'h0, d};
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrd;
  endtask
  // Instruction boundary, catch any vector load, wait for release
  task automatic step(input logic t, input logic r);
    va = 16'h0;
    @(posedge clk);
    {iend, trp, irt} <= {1'b1, t, r};
    @(posedge clk);
    {iend, trp, irt} <= 3'h0;
    repeat (20)
    begin
      @(posedge clk);
      if (vld === 1'b1) va = vadr;
    end
    while (hold !== 1'b0) @(posedge clk);
  endtask
  // Flag drop plus clear sequence, then return
  task automatic done(input int f, input logic [3:0] c);
    @(posedge clk);
    flg[f] <= 1'b0;
    clr <= c;
    @(posedge clk);
    clr <= 4'h0;
    step(1'b0, 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    do @(posedge clk); while (vld !== 1'b1);
    check("reset vector", vadr, 16'hFFFE);
    while (hold !== 1'b0) @(posedge clk);
    check("mask after reset", msk, 1'b1);
    ahb(1'b1, 8'h14, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h14, 32'h0);
    check("unmapped read", rd, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_ext;
    ahb(1'b1, 8'h08, 32'h1);
    ahb(1'b1, 8'h00, 32'h0);
    pa[0] <= 1'b0;
    repeat (5) @(posedge clk);
    step(1'b0, 1'b0);
    check("line zero vector", va, 16'hFFF6);
    check("mask on entry", msk, 1'b1);
    check("push count", npush, 8'h05);
    check("pcl stacked", u_stk.mem[8'hFF], 8'h34);
    step(1'b1, 1'b0);
    check("trap vector", va, 16'hFFFC);
    pa[0] <= 1'b1;
    repeat (5) @(posedge clk);
    step(1'b0, 1'b1);
    check("trap cc restored", rsv[4], 8'h08);
    check("trap pch restored", rsv[1], 8'h12);
    step(1'b0, 1'b1);
    check("cc restored", rsv[4], 8'h00);
    check("pcl restored", rsv[0], 8'h34);
    check("return vector", va, 16'h0);
    check("mask on return", msk, 1'b0);
    step(1'b0, 1'b0);
    check("edge latch cleared", va, 16'h0);
    $display("external line test done");
  endtask
  task automatic t_prio;
    ahb(1'b1, 8'h0C, 32'h2005);
    flg[2:0] <= 3'h5;
    step(1'b0, 1'b0);
    check("sync first", va, 16'hFFEC);
    done(0, 4'h1);
    step(1'b0, 1'b0);
    check("timer a next", va, 16'hFFEA);
    done(2, 4'h2);
    $display("priority test done");
  endtask
  task automatic t_mask;
    ahb(1'b1, 8'h00, 32'h1);
    flg[13] <= 1'b1;
    step(1'b0, 1'b0);
    check("masked request", va, 16'h0);
    ahb(1'b1, 8'h00, 32'h0);
    step(1'b0, 1'b0);
    check("pending served", va, 16'hFFE6);
    done(13, 4'h8);
    $display("mask test done");
  endtask
  // Wait (h low) or Halt (h high), then wake it
  task automatic t_sleep(input logic h);
    int n = 0;
    ahb(1'b1, 8'h00, 32'h1);
    {iend, wt, ht} <= {1'b1, !h, h};
    @(posedge clk);
    {iend, wt, ht} <= 3'h0;
    repeat (4) @(posedge clk);
    check("sleep unmasked", msk, 1'b0);
    check("oscillator on", osc, !h);
    flg[0] <= 1'b1;
    if (h)
    begin
      repeat (8) @(posedge clk);
      check("halt kept", osc, 1'b0);
      pa[0] <= 1'b0;
    end
    do
    begin
      @(posedge clk);
      n++;
    end
    while (vld !== 1'b1);
    check("wake vector", vadr, h ? 16'hFFF6 : 16'hFFEC);
    check("wake delay", n > 4096, h);
    pa[0] <= 1'b1;
    done(0, 4'h1);
    $display("sleep test done");
  endtask
  // Verdict
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_ext;
    t_prio;
    t_mask;
    t_sleep(1'b0);
    t_sleep(1'b1);
    stop_test;
  end
endmodule
`default_nettype wire

// File: verif/mic_stack_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stack RAM answering the sequencer's push and pop strobes
module mic_stack_model (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        we_in,
  input  wire logic        re_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  output logic      [7:0]  rdata_out,
  output logic      [7:0]  n_push_out
);
  logic [7:0] mem [0:255]; // One stack page
  // Store pushes, answer a pop next cycle, toggle junk otherwise
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      n_push_out <= 8'h00;
      rdata_out  <= 8'h5A;
    end
    else
    begin
      if (we_in)
      begin
        mem[addr_in[7:0]] <= wdata_in;
        n_push_out        <= n_push_out + 8'h01;
      end
      rdata_out <= re_in ? mem[addr_in[7:0]] : ~rdata_out;
    end
  end
endmodule
`default_nettype wire
